/* rtl/acp_pkg.sv */
// Constants and helpers shared by both ends of the ADC parallel port
// Notes on behaviour
// - Both sequence bits set: step 0 to last
// - Sequence repeats until next control write
// - Host keeps write strobe high during sequence
// - Reference bit 1 internal, 0 external
// - Start falling edge begins conversion, busy high
// - Start high before 14th clock fall aborts
// - Busy falls when conversion completes
// - Host gives rising edge, then 125 ns acquisition
// - Hold on start fall, track at 13th rise
// - Auto power-down: start rising edge powers up
// - Data port 12 or 10 bits wide
// - Word mode: one read, shared pin is bit 8
// - Byte mode: two byte reads, select picks half
// - Low byte: eight LSBs, 10-bit padded zeros
// - High byte: MSBs, zero, channel identifier
// - Drivers on only while select and read low
// - Drive after both low, release after read
// - Strobes held low: result before busy falls
// - Host avoids reading during conversion
// - Both sequence bits clear: single addressed channel
// - Control captured at write strobe rising edge
// - Byte mode control write takes two writes
`default_nettype none
package acp_pkg;
    // =========================================================
    // Control word layout
    localparam int CTL_PM_LSB = 0;
    localparam int CTL_REF    = 2;
    localparam int CTL_SEQUENCE_BIT0   = 3;
    localparam int CTL_SEQUENCE_BIT1   = 4;
    localparam int CTL_LAST_CHANNEL_BIT0   = 5;
    localparam int CTL_LAST_CHANNEL_BIT1   = 6;
    localparam logic [11:0] CTL_RESET = 12'h000;
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_AUTO_SD = 2'h1;
    localparam logic [1:0] PM_AUTO_SB = 2'h2;
    localparam logic [1:0] PM_FULL_SD = 2'h3;
    // =========================================================
    // Conversion timing in conversion clock edges
    localparam logic [3:0] CONV_FALLS = 4'hE;
    localparam logic [3:0] TRACK_RISE = 4'hD;
    localparam logic [5:0] HI_BYTE_ZERO = 6'h00;
    // =========================================================
    // Times and cycle counts at 200 MHz
    localparam int CLK_MHZ          = 200;
    localparam int T_ACQ_NS         = 125;
    localparam int T_PU_SHDN_US     = 10_000;
    localparam int T_PU_SB_EXT_NS   = 600;
    localparam int T_PU_SB_INT_NS   = 7000;
    localparam int ACQ_CYC    = (T_ACQ_NS * CLK_MHZ + 999) / 1000;
    localparam int PU_SHDN_CYC = T_PU_SHDN_US * CLK_MHZ;
    localparam int PU_EXT_CYC = (T_PU_SB_EXT_NS * CLK_MHZ + 999) / 1000;
    localparam int PU_INT_CYC = (T_PU_SB_INT_NS * CLK_MHZ + 999) / 1000;
    // =========================================================
    // Host command registers
    localparam logic [1:0] REG_CMD    = 2'h0;
    localparam logic [1:0] REG_CTRL   = 2'h1;
    localparam logic [1:0] REG_RESULT = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;
    localparam int CMD_CONV = 0;
    localparam int CMD_WR   = 1;
    localparam int RD_CYC   = 4;
    localparam int WR_CYC   = 3;

    function automatic logic fell(input logic prev, input logic now);
        return prev & ~now;
    endfunction

    function automatic logic rose(input logic prev, input logic now);
        return ~prev & now;
    endfunction
endpackage
`default_nettype wire

/* rtl/acp_if.sv */
// Pin-level interface between ADC port and its host controller
`default_nettype none
interface acp_if;
    logic        conversion_start_n;
    logic        conversion_clock_in;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        word_byte;
    logic        busy;
    logic [11:0] dev_db_out;
    logic [11:0] dev_db_oe;
    logic [11:0] host_db_out;
    logic [11:0] host_db_oe;
    logic [11:0] db;

    // Wire level; undriven lines pulled high
    assign db = (dev_db_oe & dev_db_out)
              | (~dev_db_oe & host_db_oe & host_db_out)
              | (~dev_db_oe & ~host_db_oe);

    modport dev (
        input  conversion_start_n, conversion_clock_in, cs_n, rd_n,
        input  wr_n, word_byte, db,
        output busy, dev_db_out, dev_db_oe
    );

    modport host (
        output conversion_start_n, conversion_clock_in, cs_n, rd_n,
        output wr_n, word_byte, host_db_out, host_db_oe,
        input  busy, db
    );
endinterface
`default_nettype wire

/* rtl/acp_sar.sv */
// Successive approximation core stepping one bit per clock fall
`default_nettype none
module acp_sar #(
    parameter int RES = 12
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        start,
    input  wire logic        step,
    // Sampled input and reference
    input  wire logic [15:0] vin,
    input  wire logic [15:0] vref,
    // Result
    output logic      [11:0] code
);
    typedef struct packed {
        logic [15:0] vin;
        logic [15:0] vref;
        logic [11:0] code;
        logic [3:0]  bitp;
    } acp_sar_state_t;

    acp_sar_state_t s;
    acp_sar_state_t next_s;
    logic [11:0]    trial;

    always_comb begin
        next_s = s;
        trial  = s.code | (12'h001 << s.bitp);
        if (start) begin
            next_s.vin  = vin;
            next_s.vref = vref;
            next_s.code = 12'h000;
            next_s.bitp = 4'(RES - 1);
        end else if (step) begin
            // Keep trial bit if its level does not exceed the input
            if (32'(trial) * 32'(s.vref) <= (32'(s.vin) << RES))
                next_s.code = trial;
            next_s.bitp = s.bitp - 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign code = s.code;
endmodule
`default_nettype wire

/* rtl/acp_device.sv */
// Converter end: control word, sequencer, conversion and read port
`default_nettype none
module acp_device #(
    parameter int RES         = 12,
    parameter int PU_SHDN_CYC = acp_pkg::PU_SHDN_CYC,
    parameter int INT_REF_MV  = 2500
) (
    // System
    input  wire logic            CLK_SYS,
    input  wire logic            SYS_RST,
    // Pins
    acp_if.dev                   bus,
    // Analog side as millivolt codes
    input  wire logic [3:0][15:0] ANALOG_IN,
    input  wire logic [15:0]      EXT_REF_MV,
    // Status
    output logic                  HOLD,
    output logic                  POWERED,
    output logic                  REF_INTERNAL,
    output logic [1:0]            CHANNEL_ID
);
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_FIN} acp_dev_st_t;

    typedef struct packed {
        logic        cs_n_q;
        logic        wr_n_q;
        logic        cv_q;
        logic        ck_q;
        logic [11:0] ctl;
        logic [7:0]  wr_lo;
        acp_dev_st_t st;
        logic [3:0]  nfall;
        logic [3:0]  nrise;
        logic [1:0]  seq_ch;
        logic [1:0]  chan;
        logic [1:0]  id;
        logic [11:0] res;
        logic        busy;
        logic        hold;
        logic        powered;
        logic [20:0] pu;
        logic [11:0] db_out;
        logic [11:0] db_oe;
    } acp_dev_state_t;

    acp_dev_state_t s;
    acp_dev_state_t next_s;

    logic        conv_fall;
    logic        conv_rise;
    logic        ck_fall;
    logic        ck_rise;
    logic        wr_done;
    logic        commit;
    logic        hbs;
    logic        consec;
    logic [1:0]  pm;
    logic [1:0]  last_ch;
    logic [1:0]  sel;
    logic        sar_start;
    logic        sar_step;
    logic [11:0] sar_code;
    logic [11:0] aligned;
    logic [11:0] word_mask;
    logic [15:0] vref;

    // =========================================================
    // Conversion core
    assign vref = s.ctl[acp_pkg::CTL_REF] ? 16'(INT_REF_MV)
                                          : EXT_REF_MV;

    acp_sar #(
        .RES   (RES)
    ) u_sar (
        .clk   (CLK_SYS),
        .rst   (SYS_RST),
        .start (sar_start),
        .step  (sar_step),
        .vin   (ANALOG_IN[sel]),
        .vref  (vref),
        .code  (sar_code)
    );

    // Ten-bit results sit on the upper ten lines
    assign aligned   = 12'(sar_code << (12 - RES));
    assign word_mask = (RES == 12) ? 12'hFFF : 12'hFFC;

    // =========================================================
    // Next state
    always_comb begin
        next_s    = s;
        sar_start = 1'b0;
        sar_step  = 1'b0;
        commit    = 1'b0;

        next_s.cs_n_q = bus.cs_n;
        next_s.wr_n_q = bus.wr_n;
        next_s.cv_q   = bus.conversion_start_n;
        next_s.ck_q   = bus.conversion_clock_in;

        conv_fall = acp_pkg::fell(s.cv_q, bus.conversion_start_n);
        conv_rise = acp_pkg::rose(s.cv_q, bus.conversion_start_n);
        ck_fall   = acp_pkg::fell(s.ck_q, bus.conversion_clock_in);
        ck_rise   = acp_pkg::rose(s.ck_q, bus.conversion_clock_in);
        wr_done   = acp_pkg::rose(s.wr_n_q, bus.wr_n) & ~s.cs_n_q;
        hbs       = bus.db[8];

        // Control write on strobe release
        if (wr_done) begin
            if (bus.word_byte) begin
                next_s.ctl = bus.db;
                commit     = 1'b1;
            end else if (!hbs) begin
                next_s.wr_lo = bus.db[7:0];
            end else begin
                next_s.ctl = {bus.db[3:0], s.wr_lo};
                commit     = 1'b1;
            end
        end

        pm      = next_s.ctl[acp_pkg::CTL_PM_LSB +: 2];
        consec  = next_s.ctl[acp_pkg::CTL_SEQUENCE_BIT0]
                & next_s.ctl[acp_pkg::CTL_SEQUENCE_BIT1];
        last_ch = {next_s.ctl[acp_pkg::CTL_LAST_CHANNEL_BIT1],
                   next_s.ctl[acp_pkg::CTL_LAST_CHANNEL_BIT0]};
        sel     = consec ? s.seq_ch : last_ch;

        // Power-up countdown
        if (s.pu != 21'h0_0000) begin
            next_s.pu = s.pu - 21'h0_0001;
            if (s.pu == 21'h0_0001)
                next_s.powered = 1'b1;
        end

        if (commit) begin
            next_s.seq_ch = 2'h0;
            if (pm == acp_pkg::PM_FULL_SD) begin
                next_s.powered = 1'b0;
                next_s.pu      = 21'h0_0000;
                next_s.hold    = 1'b1;
            end else if (!s.powered && s.pu == 21'h0_0000) begin
                next_s.pu   = 21'(PU_SHDN_CYC);
                next_s.hold = 1'b0;
            end
        end

        // Wake from automatic power-down
        if (conv_rise && !s.powered && s.pu == 21'h0_0000
            && (pm == acp_pkg::PM_AUTO_SD
                || pm == acp_pkg::PM_AUTO_SB)) begin
            if (pm == acp_pkg::PM_AUTO_SD)
                next_s.pu = 21'(PU_SHDN_CYC);
            else if (s.ctl[acp_pkg::CTL_REF])
                next_s.pu = 21'(acp_pkg::PU_INT_CYC);
            else
                next_s.pu = 21'(acp_pkg::PU_EXT_CYC);
            next_s.hold = 1'b0;
        end

        unique case (s.st)
            ST_IDLE: begin
                if (conv_rise && s.powered)
                    next_s.hold = 1'b0;
                if (conv_fall && s.powered) begin
                    next_s.st    = ST_CONV;
                    next_s.busy  = 1'b1;
                    next_s.hold  = 1'b1;
                    next_s.nfall = 4'h0;
                    next_s.nrise = 4'h0;
                    next_s.chan  = sel;
                    sar_start    = 1'b1;
                end
            end
            ST_CONV: begin
                if (ck_fall)
                    next_s.nfall = s.nfall + 4'h1;
                if (ck_rise)
                    next_s.nrise = s.nrise + 4'h1;
                if (ck_rise && next_s.nrise == acp_pkg::TRACK_RISE)
                    next_s.hold = 1'b0;
                sar_step = ck_fall && (s.nfall < 4'(RES));
                if (ck_fall && next_s.nfall == acp_pkg::CONV_FALLS) begin
                    next_s.st  = ST_FIN;
                    next_s.res = aligned;
                    next_s.id  = s.chan;
                    if (consec)
                        next_s.seq_ch = (s.seq_ch == last_ch)
                                      ? 2'h0
                                      : s.seq_ch + 2'h1;
                end else if (bus.conversion_start_n) begin
                    next_s.st   = ST_IDLE;
                    next_s.busy = 1'b0;
                    next_s.hold = 1'b0;
                end
            end
            ST_FIN: begin
                next_s.st   = ST_IDLE;
                next_s.busy = 1'b0;
                if (pm == acp_pkg::PM_AUTO_SD
                    || pm == acp_pkg::PM_AUTO_SB) begin
                    next_s.powered = 1'b0;
                    next_s.hold    = 1'b1;
                end
            end
        endcase

        // Read port; data follows the result register at once
        if (!bus.cs_n && !bus.rd_n) begin
            if (bus.word_byte)
                next_s.db_oe = word_mask;
            else
                next_s.db_oe = 12'h0FF;
        end else begin
            next_s.db_oe = 12'h000;
        end
        if (bus.word_byte)
            next_s.db_out = next_s.res;
        else if (hbs)
            next_s.db_out = {4'h0, 1'b0, next_s.id, 1'b0,
                             next_s.res[11:8]};
        else
            next_s.db_out = {4'h0, next_s.res[7:0]};
    end

    // =========================================================
    // State register
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            s         <= '0;
            s.cs_n_q  <= 1'b1;
            s.wr_n_q  <= 1'b1;
            s.ctl     <= acp_pkg::CTL_RESET;
            s.st      <= ST_IDLE;
            s.hold    <= 1'b1;
            s.powered <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // =========================================================
    // Outputs
    assign bus.busy       = s.busy;
    assign bus.dev_db_out = s.db_out;
    assign bus.dev_db_oe  = s.db_oe;
    assign HOLD           = s.hold;
    assign POWERED        = s.powered;
    assign REF_INTERNAL   = s.ctl[acp_pkg::CTL_REF];
    assign CHANNEL_ID     = s.id;
endmodule
`default_nettype wire

/* rtl/acp_host.sv */
// Host end: drives conversion, writes control, reads results
`default_nettype none
module acp_host #(
    parameter logic WORD_MODE = 1'b1,
    parameter int   CLK_HALF  = 4
) (
    // System
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    // Command port
    input  wire logic [1:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    // Pins
    acp_if.host              bus
);
    typedef enum logic [2:0] {
        H_INIT, H_ACQ, H_IDLE, H_CONV, H_WAITB, H_XFER
    } acp_host_st_t;

    typedef struct packed {
        acp_host_st_t st;
        logic [7:0]   cnt;
        logic [7:0]   div;
        logic         ck;
        logic         ck_q;
        logic [3:0]   nfall;
        logic         cv;
        logic         strobe_n;
        logic         is_wr;
        logic         phase;
        logic [11:0]  dout;
        logic [11:0]  doe;
        logic [11:0]  ctl;
        logic [15:0]  res;
        logic         done;
        logic         pend_conv;
        logic         pend_wr;
        logic [15:0]  rdata;
    } acp_host_state_t;

    acp_host_state_t s;
    acp_host_state_t next_s;
    logic            last;

    always_comb begin
        next_s       = s;
        next_s.rdata = 16'h0000;
        next_s.ck_q  = s.ck;
        last         = WORD_MODE | s.phase;
        // Conversion clock divider
        if (s.div == 8'(CLK_HALF - 1)) begin
            next_s.div = 8'h00;
            next_s.ck  = ~s.ck;
        end else begin
            next_s.div = s.div + 8'h01;
        end

        unique case (s.st)
            H_INIT: begin
                next_s.cv  = 1'b1;
                next_s.st  = H_ACQ;
                next_s.cnt = 8'h00;
            end
            H_ACQ, H_IDLE: begin
                if (s.cnt != 8'(acp_pkg::ACQ_CYC))
                    next_s.cnt = s.cnt + 8'h01;
                else if (s.st == H_ACQ)
                    next_s.st = H_IDLE;
                else if (s.pend_wr) begin
                    next_s.pend_wr  = 1'b0;
                    next_s.st       = H_XFER;
                    next_s.is_wr    = 1'b1;
                    next_s.phase    = 1'b0;
                    next_s.cnt      = 8'h00;
                    next_s.strobe_n = 1'b0;
                end else if (s.pend_conv && !s.ck) begin
                    next_s.pend_conv = 1'b0;
                    next_s.cv        = 1'b0;
                    next_s.nfall     = 4'h0;
                    next_s.st        = H_CONV;
                end
            end
            H_CONV: begin
                if (s.ck_q && !s.ck)
                    next_s.nfall = s.nfall + 4'h1;
                if (s.nfall == acp_pkg::CONV_FALLS) begin
                    next_s.cv = 1'b1;
                    next_s.st = H_WAITB;
                end
            end
            H_WAITB: begin
                if (!bus.busy) begin
                    next_s.st       = H_XFER;
                    next_s.is_wr    = 1'b0;
                    next_s.phase    = 1'b0;
                    next_s.cnt      = 8'h00;
                    next_s.strobe_n = 1'b0;
                end
            end
            H_XFER: begin
                next_s.cnt = s.cnt + 8'h01;
                if (s.is_wr && s.cnt == 8'h00) begin
                    next_s.doe = WORD_MODE ? 12'hFFF : 12'h0FF;
                    if (WORD_MODE)
                        next_s.dout = s.ctl;
                    else if (s.phase)
                        next_s.dout = {4'h0, 4'h0, s.ctl[11:8]};
                    else
                        next_s.dout = {4'h0, s.ctl[7:0]};
                end
                if (!s.is_wr && s.cnt == 8'(acp_pkg::RD_CYC - 1)) begin
                    next_s.strobe_n = 1'b1;
                    if (WORD_MODE)
                        next_s.res = {4'h0, bus.db};
                    else if (s.phase)
                        next_s.res[13:8] = {bus.db[6:5],
                                            bus.db[3:0]};
                    else
                        next_s.res[7:0] = bus.db[7:0];
                end
                if (s.is_wr && s.cnt == 8'(acp_pkg::WR_CYC))
                    next_s.strobe_n = 1'b1;
                if (s.cnt == 8'(acp_pkg::WR_CYC + 1)
                    || (!s.is_wr && s.cnt == 8'(acp_pkg::RD_CYC))) begin
                    next_s.doe      = 12'h000;
                    next_s.cnt      = 8'h00;
                    next_s.phase    = 1'b1;
                    next_s.strobe_n = last;
                    if (last) begin
                        next_s.st   = H_IDLE;
                        next_s.done = ~s.is_wr | s.done;
                    end
                end
            end
            default: next_s.st = H_IDLE;
        endcase

        // Shared pin carries the byte select in byte mode
        next_s.dout[8] = WORD_MODE ? next_s.dout[8] : next_s.phase;
        next_s.doe[8]  = WORD_MODE ? next_s.doe[8] : 1'b1;

        // Command port; a set in the same cycle wins over a clear
        if (RD) begin
            unique case (ADDR)
                acp_pkg::REG_CMD:    next_s.rdata = 16'h0000;
                acp_pkg::REG_CTRL:   next_s.rdata = {4'h0, s.ctl};
                acp_pkg::REG_RESULT: next_s.rdata = s.res;
                acp_pkg::REG_STATUS:
                    next_s.rdata = {11'h000, s.done, bus.busy,
                                    s.pend_wr, s.pend_conv,
                                    s.st == H_IDLE};
            endcase
            if (ADDR == acp_pkg::REG_RESULT && !(next_s.done & ~s.done))
                next_s.done = 1'b0;
        end
        if (WR) begin
            if (ADDR == acp_pkg::REG_CTRL)
                next_s.ctl = WDATA[11:0];
            if (ADDR == acp_pkg::REG_CMD) begin
                next_s.pend_conv = next_s.pend_conv
                                 | WDATA[acp_pkg::CMD_CONV];
                next_s.pend_wr   = next_s.pend_wr
                                 | WDATA[acp_pkg::CMD_WR];
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            s          <= '0;
            s.st       <= H_INIT;
            s.strobe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign RDATA                   = s.rdata;
    assign bus.conversion_start_n  = s.cv;
    assign bus.conversion_clock_in = s.ck;
    assign bus.cs_n                = s.strobe_n;
    assign bus.rd_n                = s.strobe_n | s.is_wr;
    assign bus.wr_n                = s.strobe_n | ~s.is_wr;
    assign bus.word_byte           = WORD_MODE;
    assign bus.host_db_out         = s.dout;
    assign bus.host_db_oe          = s.doe;
endmodule
`default_nettype wire

/* verification/acp_port_sva.sv */
// Pin checker for the ADC parallel port
`default_nettype none
module acp_port_sva (
    // System
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    // Pins
    input wire logic        conversion_start_n,
    input wire logic        conversion_clock_in,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic        word_byte,
    input wire logic        busy,
    input wire logic [11:0] dev_db_out,
    input wire logic [11:0] dev_db_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       ck_q;
    logic       st_q;
    logic [3:0] nf;
    wire        ck_fell = ck_q & ~conversion_clock_in;
    // ==========================================================
    // Conversion clock falls since start fell
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ck_q <= 1'b0;
            st_q <= 1'b0;
            nf <= 4'h0;
        end else begin
            ck_q <= conversion_clock_in;
            st_q <= conversion_start_n;
            if (st_q & ~conversion_start_n)
                nf <= 4'h0;
            else if (ck_fell && nf != 4'hF)
                nf <= nf + 4'h1;
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    sequence s_done;
        busy ##1 !busy;
    endsequence
    a_busy_start: assert property (
        $fell(conversion_start_n) && !busy |=> busy)
        else $error("busy missing after start");
    a_busy_hold: assert property (
        busy && !conversion_start_n && nf < 4'hE |=> busy)
        else $error("busy dropped early");
    a_busy_done: assert property (
        busy && ck_fell && nf == 4'hD |=> s_done)
        else $error("busy not ended on time");
    a_start_hold: assert property (
        $rose(conversion_start_n) && busy |-> nf >= 4'hE)
        else $error("start raised early");
    a_oe_release: assert property (
        cs_n || rd_n |=> dev_db_oe == 12'h000)
        else $error("bus driven outside read");
    a_oe_byte: assert property (
        !cs_n && !rd_n && !word_byte |=> dev_db_oe[7:0] == 8'hFF)
        else $error("byte read not driven");
    a_data_settled: assert property (
        $fell(busy) |-> $stable(dev_db_out))
        else $error("data changed at busy fall");
    a_wr_quiet: assert property (busy |-> wr_n)
        else $error("write during conversion");
    a_rd_quiet: assert property (busy |-> rd_n)
        else $error("read during conversion");
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Bench joining host and converter ends across the pins
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic [1:0]       addr = 2'h0;
    logic [15:0]      wdata = 16'h0000;
    logic             wr = 1'b0;
    logic             rd = 1'b0;
    logic             res_d = 1'b0;
    logic [15:0]      rdata;
    logic [3:0][15:0] ain;
    logic [15:0]      eref = 16'h0FA0;
    logic             ref_int;
    logic             hold;
    logic [1:0]       ch_id;
    logic [15:0]      exp_q[$];
    int               n_mismatch = 0;
    int               n_compared = 0;
    int               cyc = 0;
    int               seed = 32'h1edc_435f;
    acp_if ab();
    always #2.5 clk = ~clk;
    acp_host #(.WORD_MODE(1'b0)) acp_host_i (.CLK_SYS(clk), .SYS_RST(rst),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .bus(ab));
    acp_device #(.PU_SHDN_CYC(20)) acp_device_i (.CLK_SYS(clk),
        .SYS_RST(rst), .bus(ab), .ANALOG_IN(ain), .EXT_REF_MV(eref),
        .HOLD(hold), .POWERED(), .REF_INTERNAL(ref_int), .CHANNEL_ID(ch_id));
    acp_port_sva acp_port_sva_i (.CLK_SYS(clk), .SYS_RST(rst),
        .conversion_start_n(ab.conversion_start_n), .cs_n(ab.cs_n),
        .conversion_clock_in(ab.conversion_clock_in), .rd_n(ab.rd_n),
        .wr_n(ab.wr_n), .word_byte(ab.word_byte), .busy(ab.busy),
        .dev_db_out(ab.dev_db_out), .dev_db_oe(ab.dev_db_oe));
    // ==========================================================
    // Command port cycles
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    function automatic logic [11:0] code(input logic [15:0] v,
                                         input logic [15:0] r);
        int c;
        c = int'(v) * 4096 / int'(r);
        return (c > 4095) ? 12'hFFF : 12'(c);
    endfunction
    task automatic ctl(input int a, input logic sq, input logic rf,
                       input logic [1:0] pm);
        wr_reg(2'h1, {9'h000, 2'(a), sq, sq, rf, pm});
        wr_reg(2'h0, 16'h0002);
    endtask
    task automatic conv(input int ch, input logic [15:0] r);
        logic [15:0] s;
        int          n;
        wr_reg(2'h0, 16'h0001);
        exp_q.push_back({2'h0, 2'(ch), code(ain[ch], r)});
        s = 16'h0000;
        n = 0;
        while (s[4] !== 1'b1 && n < 500) begin
            rd_reg(2'h3, s);
            n++;
        end
        if (n == 500)
            n_mismatch++;
        rd_reg(2'h2, s);
        `CHK(ch_id, 2'(ch))
        `CHK(hold, 1'b0)
    endtask
    task automatic end_sim();
        $display("Mismatches %0d, compares %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // Result watcher and hang guard
    always @(posedge clk) begin
        cyc++;
        res_d <= rd && addr == 2'h2;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    // Read data stands for one cycle after the strobe
    always @(negedge clk)
        if (res_d)
            `CHK(rdata, exp_q.pop_front())
    // ==========================================================
    // Scenarios
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            ain[i] <= 16'({$random(seed)} % 2500);
        for (int c = 0; c < 4; c++) begin
            ctl(c, 1'b0, 1'b0, 2'h0);
            conv(c, eref);
            `CHK(ref_int, 1'b0)
        end
        ctl(2, 1'b0, 1'b1, 2'h0);
        conv(2, 16'h09C4);
        `CHK(ref_int, 1'b1)
        ctl(2, 1'b1, 1'b0, 2'h0);
        for (int k = 0; k < 5; k++)
            conv(k % 3, eref);
        ctl(3, 1'b1, 1'b0, 2'h0);
        for (int k = 0; k < 2; k++)
            conv(k, eref);
        // Auto shutdown: second result needs the start-rise wake
        ctl(1, 1'b1, 1'b0, 2'h1);
        for (int k = 0; k < 2; k++)
            conv(k, eref);
        end_sim();
    end
endmodule
`default_nettype wire
